// [verilog/brs_sequencer.sv]
// Purpose: Decides when the pattern source may send its next block and issues reset-start
// Assumes: Busy lines come from the display controller pins; source signals are same clock
// Notes: One reset-start pulse per block; settle hold timer inside
//
// Summary of operation
// - While the controller reports busy loading, no release is given to the pattern source.
// - When the pattern source finishes a block and busy is low, a reset-start pulse goes to the controller.
// - No new start is given while the pattern source is still sending a block.
// - No new start is given while every controller busy line is high.
// - No new start is given once every enabled block has been loaded.
// - The pattern source begins no transfer until the settle after the previous reset-start has ended.
// - A possible settle violation makes the settle hold timer block start until it ends.
// - The settle interval starts on the busy falling edge, or at watchdog end if busy never showed, and no load happens during it.
// - With all blocks enabled the start is delayed by a 6 us settle time.
// - With any of the 16 blocks disabled a 6 us settle delay is always inserted.
// - In global operation the settle delay follows every collective reset.
// - Blocks sent, blocks loaded and, in slow mode, segments sent are counted.
// - A status output shows when the controller is busy loading.
// - Sending, next block address, errors and settings are reported.
// - The source control stays idle until every block-out condition clears, then starts a transfer.
`timescale 1ns/1ps
module brs_sequencer #(
	parameter int BLOCKS = brs_pkg::BLOCK_COUNT,
	parameter int ADDR_W = 4
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [BLOCKS-1:0] ctrlBusy,
	input wire logic [BLOCKS-1:0] blockEnable,
	input wire logic slowMode,
	input wire logic srcSending,
	input wire logic srcBlockDone,
	input wire logic srcSegmentDone,
	input wire logic [ADDR_W-1:0] srcNextAddr,
	input wire logic srcTimeoutErr,
	input wire logic linkErr,
	input wire logic cycleRestart,
	output logic resetStart,
	output logic srcStart,
	output logic busyStatus,
	output logic sendingStatus,
	output logic [ADDR_W-1:0] nextAddrStatus,
	output logic timeoutErrStatus,
	output logic linkErrStatus,
	output logic [BLOCKS-1:0] settingsStatus,
	output brs_pkg::brs_counts_t counts,
	output logic settleActive
);
	// Synchroniser flops for the controller busy pins
	logic [BLOCKS-1:0] busySync1;
	logic [BLOCKS-1:0] busySync2;
	logic anyBusyDly;

	// Sequencer state and settle hold timer
	brs_pkg::brs_state_t state;
	brs_pkg::brs_state_t next_state;
	logic [brs_pkg::TIMER_W-1:0] timer;
	logic [brs_pkg::TIMER_W-1:0] next_timer;
	logic startSent;
	logic next_startSent;
	logic next_resetStart;
	logic next_srcStart;
	logic next_settleActive;

	// Blocks loaded in the present pattern cycle
	logic [BLOCKS-1:0] loadedMask;
	logic [BLOCKS-1:0] next_loadedMask;

	// Progress counters
	brs_pkg::brs_counts_t next_counts;

	// Status mirrors towards the user side
	logic next_busyStatus;
	logic next_sendingStatus;
	logic [ADDR_W-1:0] next_nextAddrStatus;
	logic next_timeoutErrStatus;
	logic next_linkErrStatus;
	logic [BLOCKS-1:0] next_settingsStatus;

	// Decoded conditions
	logic anyBusy;
	logic allBusy;
	logic busyFall;
	logic allLoaded;
	logic allEnabled;
	logic blockAccepted;
	logic startAllowed;
	logic [brs_pkg::TIMER_W-1:0] settleLoad;

	// Wrapping counter step, shared by all three progress counters
	function automatic logic [brs_pkg::COUNT_W-1:0] count_step(
		input logic [brs_pkg::COUNT_W-1:0] value,
		input logic eventSeen
	);
		count_step = eventSeen ? value + 1'b1 : value;
	endfunction : count_step

	// One-hot mask for a block address
	function automatic logic [BLOCKS-1:0] block_bit(
		input logic [ADDR_W-1:0] addr
	);
		block_bit = BLOCKS'(1) << addr;
	endfunction : block_bit

	// Busy lines cross from the pins through two flops
	// Only the second stage is read, so no metastable value reaches logic
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			busySync1 <= '0;
			busySync2 <= '0;
			anyBusyDly <= 1'b0;
		end else begin
			busySync1 <= ctrlBusy;
			busySync2 <= busySync1;
			anyBusyDly <= anyBusy;
		end
	end

	// Busy decode; falling edge marks the end of a reset
	always_comb begin
		anyBusy = |busySync2;
		allBusy = &busySync2;
		busyFall = anyBusyDly && !anyBusy;
		allEnabled = &blockEnable;
		allLoaded = (blockEnable != '0) && ((loadedMask & blockEnable) == blockEnable);
		blockAccepted = srcBlockDone && (state == brs_pkg::BRS_SENDING);
		// Any busy line blocks a release, which also covers the all-busy case
		startAllowed = !srcSending && !allBusy && !allLoaded && !anyBusy;
		// Both cases use the same figure today but stay separate for tuning
		settleLoad = allEnabled ? brs_pkg::TIMER_W'(brs_pkg::SETTLE_GLOBAL_CYC)
			: brs_pkg::TIMER_W'(brs_pkg::SETTLE_PARTIAL_CYC);
	end

	// Sequencer next state and settle hold timer
	always_comb begin
		next_state = state;
		next_timer = timer;
		next_startSent = startSent;
		next_resetStart = 1'b0;
		next_srcStart = 1'b0;
		unique case (state)
			brs_pkg::BRS_IDLE: begin
				// Release the source only when every block-out condition is clear
				if (startAllowed) begin
					next_srcStart = 1'b1;
					next_state = brs_pkg::BRS_SENDING;
				end
			end
			brs_pkg::BRS_SENDING: begin
				// Source stays here until its block is done; no second release
				if (srcBlockDone) begin
					next_state = brs_pkg::BRS_WAIT_BUSY;
					next_startSent = !anyBusy;
					next_resetStart = !anyBusy;
					next_timer = anyBusy ? '0 : settleLoad;
				end
			end
			brs_pkg::BRS_WAIT_BUSY: begin
				if (!startSent) begin
					// Controller was busy at block end; reset-start once it drops
					if (!anyBusy) begin
						next_resetStart = 1'b1;
						next_startSent = 1'b1;
						next_timer = settleLoad;
					end
				end else if (busyFall) begin
					// Every reset is a settle risk; cheaper than tracking blocks
					next_timer = settleLoad;
					next_state = brs_pkg::BRS_SETTLE;
				end else if (!anyBusy && timer == '0) begin
					// Busy never showed; settle from here rather than hang
					next_timer = settleLoad;
					next_state = brs_pkg::BRS_SETTLE;
				end else if (timer != '0) begin
					// Watchdog runs while the reset is in progress
					next_timer = timer - 1'b1;
				end
			end
			brs_pkg::BRS_SETTLE: begin
				next_startSent = 1'b0;
				if (timer != '0) begin
					next_timer = timer - 1'b1;
				end else begin
					next_state = brs_pkg::BRS_IDLE;
				end
			end
		endcase
		next_settleActive = (next_state == brs_pkg::BRS_SETTLE);
	end

	// Sequencer registers; both handshake pulses come straight from flops
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state <= brs_pkg::BRS_IDLE;
			timer <= '0;
			startSent <= 1'b0;
			resetStart <= 1'b0;
			srcStart <= 1'b0;
			settleActive <= 1'b0;
		end else begin
			state <= next_state;
			timer <= next_timer;
			startSent <= next_startSent;
			resetStart <= next_resetStart;
			srcStart <= next_srcStart;
			settleActive <= next_settleActive;
		end
	end

	// Loaded tracking; a block done in the restart cycle still counts
	always_comb begin
		next_loadedMask = loadedMask;
		if (cycleRestart) begin
			next_loadedMask = '0;
		end
		if (blockAccepted) begin
			next_loadedMask = next_loadedMask | block_bit(srcNextAddr);
		end
	end

	// Loaded mask register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			loadedMask <= '0;
		end else begin
			loadedMask <= next_loadedMask;
		end
	end

	// Progress counters; they wrap rather than saturate
	always_comb begin
		next_counts = counts;
		next_counts.blocksSent = count_step(counts.blocksSent, blockAccepted);
		next_counts.blocksLoaded = count_step(counts.blocksLoaded, busyFall);
		next_counts.segmentsSent = count_step(counts.segmentsSent,
			slowMode && srcSegmentDone);
	end

	// Counter registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			counts <= '0;
		end else begin
			counts <= next_counts;
		end
	end

	// Status mirrors; one cycle late, busy three cycles behind its pins
	always_comb begin
		next_busyStatus = anyBusy;
		next_sendingStatus = srcSending;
		next_nextAddrStatus = srcNextAddr;
		next_timeoutErrStatus = srcTimeoutErr;
		next_linkErrStatus = linkErr;
		next_settingsStatus = blockEnable;
	end

	// Status registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			busyStatus <= 1'b0;
			sendingStatus <= 1'b0;
			nextAddrStatus <= '0;
			timeoutErrStatus <= 1'b0;
			linkErrStatus <= 1'b0;
			settingsStatus <= '0;
		end else begin
			busyStatus <= next_busyStatus;
			sendingStatus <= next_sendingStatus;
			nextAddrStatus <= next_nextAddrStatus;
			timeoutErrStatus <= next_timeoutErrStatus;
			linkErrStatus <= next_linkErrStatus;
			settingsStatus <= next_settingsStatus;
		end
	end
endmodule : brs_sequencer

// [common/brs_pkg.sv]
// Purpose: Shared constants and carriers for the block reset start sequencer
// Assumes: 200 MHz system clock
// Notes: Settle time kept in ns, cycle count derived from the clock period
package brs_pkg;
	localparam int BLOCK_COUNT = 16;
	localparam int CLK_PERIOD_NS = 5;
	localparam int SETTLE_GLOBAL_NS = 6000;
	localparam int SETTLE_PARTIAL_NS = 6000;
	// Least times round up to whole cycles
	localparam int SETTLE_GLOBAL_CYC = (SETTLE_GLOBAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_PARTIAL_CYC = (SETTLE_PARTIAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_W = 16;
	localparam int COUNT_W = 16;

	// Progress counters reported to the user side
	typedef struct packed {
		logic [COUNT_W-1:0] blocksSent;
		logic [COUNT_W-1:0] blocksLoaded;
		logic [COUNT_W-1:0] segmentsSent;
	} brs_counts_t;

	typedef enum logic [1:0] {
		BRS_IDLE,
		BRS_SENDING,
		BRS_WAIT_BUSY,
		BRS_SETTLE
	} brs_state_t;
endpackage : brs_pkg

// [testbench/brs_ctrl_model.sv]
// Purpose: Display controller stand-in
// Assumes: Busy held BUSY_CYC cycles per reset
// Notes: All lines move together, as in global mode
`timescale 1ns/1ps
module brs_ctrl_model #(parameter int BUSY_CYC = 40) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic resetStart,
	output logic [15:0] ctrlBusy
);
	int left;
	// Reset-start launches one busy interval
	always_ff @(posedge sys_clk) begin
		if (rst) left <= 0;
		else if (resetStart) left <= BUSY_CYC;
		else if (left > 0) left <= left - 1;
	end
	assign ctrlBusy = (left > 0) ? 16'hFFFF : 16'h0000;
endmodule : brs_ctrl_model

// [testbench/brs_sequencer_props.sv]
// Purpose: Port timing checks
// Assumes: One clock, sync reset
// Notes: Settle length is timed by the bench
`timescale 1ns/1ps
module brs_sequencer_props (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [15:0] ctrlBusy,
	input wire logic slowMode,
	input wire logic srcSending,
	input wire logic srcSegmentDone,
	input wire logic resetStart,
	input wire logic srcStart,
	input wire logic busyStatus,
	input wire brs_pkg::brs_counts_t counts,
	input wire logic settleActive
);
	// Guards on rst keep $past off forced values
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_start_idle: assert property (srcStart |-> !$past(srcSending))
		else $error("start while sending");
	a_start_busy: assert property (srcStart |-> $past(ctrlBusy, 3) == 16'h0)
		else $error("start while busy");
	a_start_pulse: assert property (srcStart |=> !srcStart)
		else $error("start too long");
	a_reset_pulse: assert property (resetStart |=> !resetStart)
		else $error("reset-start too long");
	a_settle_hold: assert property (settleActive |-> !srcStart)
		else $error("start in settle");
	a_busy_status: assert property (!$past(rst, 3) |-> busyStatus == |$past(ctrlBusy, 3))
		else $error("busy status wrong");
	a_sent_step: assert property (!$past(rst) && !$stable(counts.blocksSent)
		|-> counts.blocksSent == $past(counts.blocksSent) + 16'h1) else $error("sent jump");
	a_seg_step: assert property (!$past(rst) && $past(slowMode && srcSegmentDone)
		|-> counts.segmentsSent == $past(counts.segmentsSent) + 16'h1) else $error("seg miss");
endmodule : brs_sequencer_props
bind brs_sequencer brs_sequencer_props u_props (.sys_clk(sys_clk), .rst(rst), .ctrlBusy(ctrlBusy),
	.slowMode(slowMode), .srcSending(srcSending), .srcSegmentDone(srcSegmentDone),
	.resetStart(resetStart), .srcStart(srcStart), .busyStatus(busyStatus), .counts(counts),
	.settleActive(settleActive));

// [testbench/brs_sequencer_tb.sv]
// Purpose: Self-checking bench
// Assumes: Controller busy 40 cycles
// Notes: Rows are enables, address, sent count
`timescale 1ns/1ps
module brs_sequencer_tb;
	logic sys_clk = 0, rst = 1, slowMode = 1, srcSending = 0, srcBlockDone = 0;
	logic srcSegmentDone = 0, srcTimeoutErr = 0, linkErr = 0, cycleRestart = 0;
	logic resetStart, srcStart, settleActive, busyStat, sendStat, toutStat, linkStat;
	logic [3:0] addrStat;
	logic [15:0] setStat;
	logic [15:0] ctrlBusy, blockEnable = 16'hFFFF;
	logic [3:0] srcNextAddr = 4'h0;
	brs_pkg::brs_counts_t counts;
	int failures = 0, samples_checked = 0, cyc = 0, n;
	logic [23:0] rows [3] = '{24'hFFFF01, 24'hFFFF52, 24'h000313};
	brs_sequencer u_dut (.sys_clk(sys_clk), .rst(rst), .ctrlBusy(ctrlBusy),
		.blockEnable(blockEnable), .slowMode(slowMode), .srcSending(srcSending),
		.srcBlockDone(srcBlockDone), .srcSegmentDone(srcSegmentDone), .srcNextAddr(srcNextAddr),
		.srcTimeoutErr(srcTimeoutErr), .linkErr(linkErr), .cycleRestart(cycleRestart),
		.resetStart(resetStart), .srcStart(srcStart), .busyStatus(busyStat),
		.sendingStatus(sendStat), .nextAddrStatus(addrStat), .timeoutErrStatus(toutStat),
		.linkErrStatus(linkStat), .settingsStatus(setStat), .counts(counts),
		.settleActive(settleActive));
	brs_ctrl_model u_ctl (.sys_clk(sys_clk), .rst(rst), .resetStart(resetStart), .ctrlBusy(ctrlBusy));
	initial forever #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin failures++; finish_test(); end
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk
	// Wait for release, then send one block in one cycle
	task automatic block(input logic [3:0] addr);
		for (n = 0; srcStart !== 1'b1 && n < 3000; n++) @(posedge sys_clk) #1;
		{srcSending, srcSegmentDone, srcBlockDone, srcNextAddr} = {3'b111, addr};
		@(posedge sys_clk) #1 {srcSending, srcSegmentDone, srcBlockDone} = 3'b000;
	endtask : block
	task automatic finish_test;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : finish_test
	initial begin
		repeat (10) @(posedge sys_clk) #1;
		chk("reset start", 16'h0, {15'h0, srcStart});
		rst = 0;
		// Gap since last start must cover busy plus settle
		for (int i = 0; i < 3; i++) begin
			blockEnable = rows[i][23:8];
			block(rows[i][7:4]);
			chk("gap", 16'h1, {15'h0, i == 0 || n >= 40 + brs_pkg::SETTLE_GLOBAL_CYC});
			repeat (2) @(posedge sys_clk) #1;
			chk("sent", {12'h0, rows[i][3:0]}, counts.blocksSent);
			chk("loaded", i[15:0], counts.blocksLoaded);
			chk("segments", {12'h0, rows[i][3:0]}, counts.segmentsSent);
		end
		// Both enabled blocks now loaded: no release until a new cycle
		n = 0;
		repeat (1500) @(posedge sys_clk) #1 if (srcStart === 1'b1) n++;
		chk("parked", 16'h0, n[15:0]);
		{srcSending, srcTimeoutErr, linkErr, srcNextAddr} = {3'b111, 4'hA};
		repeat (2) @(posedge sys_clk) #1;
		chk("sending status", 16'h1, {15'h0, sendStat});
		chk("address status", 16'h000A, {12'h0, addrStat});
		chk("timeout status", 16'h1, {15'h0, toutStat});
		chk("link status", 16'h1, {15'h0, linkStat});
		chk("settings status", 16'h0003, setStat);
		chk("busy status", 16'h0, {15'h0, busyStat});
		{srcSending, srcTimeoutErr, linkErr, slowMode} = 4'b0000;
		cycleRestart = 1;
		@(posedge sys_clk) #1 cycleRestart = 0;
		block(4'h0);
		chk("restart", 16'h1, {15'h0, n < 3000});
		repeat (2) @(posedge sys_clk) #1;
		chk("sent", 16'h0004, counts.blocksSent);
		chk("loaded", 16'h0003, counts.blocksLoaded);
		chk("segments off", 16'h0003, counts.segmentsSent);
		rst = 1;
		repeat (3) @(posedge sys_clk) #1;
		chk("cleared", 16'h0, counts.blocksSent);
		finish_test();
	end
endmodule : brs_sequencer_tb
